// [verilog/mdm_pkg.sv]
// Constants, register map and types shared by the management serial master
package mdm_pkg;

    // ********************************************************
    // Register map (byte offsets, low eleven address bits)
    // ********************************************************
    localparam int ADDR_W = 11;
    localparam logic [10:0] OFF_CFG0 = 11'h500;
    localparam logic [10:0] OFF_CFG1 = 11'h504;
    localparam logic [10:0] OFF_TXD = 11'h508;
    localparam logic [10:0] OFF_RXD = 11'h50C;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int DIV_W = 6;
    localparam int CFG0_EN_BIT = 6;
    localparam int CFG1_PRT_LSB = 24;
    localparam int CFG1_DEV_LSB = 16;
    localparam int CFG1_OP_LSB = 14;
    localparam int CFG1_START_BIT = 11;
    localparam int CFG1_READY_BIT = 7;
    localparam logic [5:0] DIV_RESET = 6'h00;

    // ********************************************************
    // Bus responses
    // ********************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************
    // Serial frame layout
    // ********************************************************
    localparam logic [1:0] OP_ADDR = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ_INC = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] START_CODE = 2'h0;
    localparam logic [1:0] TA_WRITE = 2'h2;
    localparam logic [5:0] BIT_PRE_LAST = 6'h1F;
    localparam logic [5:0] BIT_OP_HI = 6'h22;
    localparam logic [5:0] BIT_RELEASE = 6'h2E;
    localparam logic [5:0] BIT_DATA_FIRST = 6'h30;
    localparam logic [5:0] BIT_LAST = 6'h3F;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_SHIFT = 2'b10
    } mdm_eng_e;

endpackage : mdm_pkg

// [verilog/mdm_engine.sv]
// Serial frame engine: clock divider, shifter and read capture
`timescale 1ns/1ps
module mdm_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Frame request
    input wire logic start,
    input wire logic [5:0] div,
    input wire logic [1:0] op,
    input wire logic [4:0] prtad,
    input wire logic [4:0] devad,
    input wire logic [15:0] txd,
    // Frame result
    output logic done,
    output logic [15:0] rxd,
    // Serial pins
    output logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n
);
    import mdm_pkg::*;

    typedef struct packed {
        mdm_eng_e st;
        logic [5:0] dv;
        logic [5:0] cnt;
        logic [5:0] bit_idx;
        logic mdc;
        logic oe_n;
        logic rd;
        logic [63:0] sh;
        logic [15:0] rx;
        logic done;
    } mdm_eng_s;

    mdm_eng_s eng_reg;
    mdm_eng_s eng_next;

    // Next state; the divisor is latched per frame so a rewrite cannot bend MDC
    always_comb begin
        eng_next = eng_reg;
        eng_next.done = 1'b0;
        case (eng_reg.st)
            ENG_IDLE: begin
                eng_next.mdc = 1'b0;
                eng_next.oe_n = 1'b1;
                eng_next.cnt = '0;
                if (start) begin
                    eng_next.st = ENG_SHIFT;
                    eng_next.dv = div;
                    eng_next.bit_idx = '0;
                    eng_next.rd = op[1];
                    eng_next.oe_n = 1'b0;
                    eng_next.sh = {PREAMBLE, START_CODE, op, prtad, devad, TA_WRITE, txd};
                end
            end
            ENG_SHIFT: begin
                if (eng_reg.cnt == eng_reg.dv) begin
                    eng_next.cnt = '0;
                    if (!eng_reg.mdc) begin
                        // Rising edge: the PHY's data is sampled here
                        eng_next.mdc = 1'b1;
                        if (eng_reg.rd && eng_reg.bit_idx >= BIT_DATA_FIRST) begin
                            eng_next.rx = {eng_reg.rx[14:0], mdio_in};
                        end
                    end else begin
                        // Falling edge: next bit goes out, giving the PHY a full half period
                        eng_next.mdc = 1'b0;
                        if (eng_reg.bit_idx == BIT_LAST) begin
                            eng_next.st = ENG_IDLE;
                            eng_next.done = 1'b1;
                            eng_next.oe_n = 1'b1;
                        end else begin
                            eng_next.bit_idx = eng_reg.bit_idx + 6'h01;
                            eng_next.sh = {eng_reg.sh[62:0], 1'b0};
                            // Read frames hand the line to the PHY from turnaround on
                            eng_next.oe_n = eng_reg.rd && (eng_reg.bit_idx + 6'h01 >= BIT_RELEASE);
                        end
                    end
                end else begin
                    eng_next.cnt = eng_reg.cnt + 6'h01;
                end
            end
            default: begin
                eng_next.st = ENG_IDLE;
                eng_next.oe_n = 1'b1;
                eng_next.mdc = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eng_reg <= '{st: ENG_IDLE, oe_n: 1'b1, default: '0};
        end else begin
            eng_reg <= eng_next;
        end
    end

    assign done = eng_reg.done;
    assign rxd = eng_reg.rx;
    assign mdc = eng_reg.mdc;
    assign mdio_out = eng_reg.sh[63];
    assign mdio_oe_n = eng_reg.oe_n;

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_mdc_tick;
        @(posedge clk) disable iff (!rst_n)
        (eng_reg.st == ENG_SHIFT && eng_reg.mdc != eng_next.mdc) |-> eng_reg.cnt == eng_reg.dv;
    endproperty
    a_mdc_tick: assert property (p_mdc_tick) else $error("MDC toggled off divider tick");

    property p_preamble;
        @(posedge clk) disable iff (!rst_n)
        (eng_reg.st == ENG_SHIFT && eng_reg.bit_idx <= BIT_PRE_LAST) |-> mdio_out && !mdio_oe_n;
    endproperty
    a_preamble: assert property (p_preamble) else $error("Preamble bit not driven high");

    property p_read_release;
        @(posedge clk) disable iff (!rst_n)
        (eng_reg.st == ENG_SHIFT && eng_reg.rd && eng_reg.bit_idx >= BIT_RELEASE) |-> mdio_oe_n;
    endproperty
    a_read_release: assert property (p_read_release) else $error("Line driven during read");

    property p_opcode_sent;
        @(posedge clk) disable iff (!rst_n)
        (eng_reg.st == ENG_IDLE && start) |=> eng_reg.sh[29:28] == $past(op)
            && eng_reg.sh[15:0] == $past(txd);
    endproperty
    a_opcode_sent: assert property (p_opcode_sent) else $error("Opcode not placed in frame");

    c_read_frame: cover property (@(posedge clk) disable iff (!rst_n) done && eng_reg.rd);
    c_write_frame: cover property (@(posedge clk) disable iff (!rst_n) done && !eng_reg.rd);

endmodule : mdm_engine

// [verilog/mdm_top.sv]
// Register slave and frame control for the management serial master
//
// What this block does
// - Slave on host clock, async low reset
// - Responses: 00 okay, 10 slave error
// - Decode only address bits ten to zero
// - Serial clock is host clock over 2(div+1)
// - Divisor resets zero; zero blocks enabling
// - Start bit plus ready starts a frame, only while enabled
// - Data line as in, out, enable
// - Opcode 00 sends an address frame
// - Opcode 01 sends a write frame
// - Opcode 11 reads; data captured
// - Opcode 10 reads and post-increments
// - Target from port and device fields
// - Completion sets ready, clears start bit
`timescale 1ns/1ps
module mdm_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Write address and data
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // Write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Read address and data
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Serial management pins
    output logic MDC,
    input wire logic MDIO_IN,
    output logic MDIO_OUT,
    output logic MDIO_OE_N
);
    import mdm_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [5:0] div;
        logic en;
        logic [4:0] prtad;
        logic [4:0] devad;
        logic [1:0] op;
        logic busy;
        logic start_p;
        logic [15:0] txd;
        logic [15:0] rxd;
    } mdm_top_s;

    mdm_top_s top_reg;
    mdm_top_s top_next;
    logic eng_done;
    logic [15:0] eng_rxd;

    // Address match on the low eleven bits only
    function automatic logic addr_hit(input logic [31:0] addr, input logic [10:0] off);
        addr_hit = (addr[ADDR_W-1:0] == off);
    endfunction : addr_hit

    // Read view of the frame control register
    function automatic logic [31:0] cfg1_view(input mdm_top_s s);
        logic [31:0] v;
        v = '0;
        v[CFG1_PRT_LSB +: 5] = s.prtad;
        v[CFG1_DEV_LSB +: 5] = s.devad;
        v[CFG1_OP_LSB +: 2] = s.op;
        v[CFG1_START_BIT] = s.busy;
        v[CFG1_READY_BIT] = !s.busy;
        cfg1_view = v;
    endfunction : cfg1_view

    // ********************************************************
    // Bus slave and register file
    // ********************************************************
    // One access of each kind at a time; ready is raised for one cycle only
    always_comb begin
        top_next = top_reg;
        top_next.start_p = 1'b0;
        // Write channel
        if (top_reg.awready) begin
            top_next.awready = 1'b0;
            top_next.wready = 1'b0;
            top_next.bvalid = 1'b1;
            top_next.bresp = RESP_OKAY;
            if (addr_hit(S_AXI_AWADDR, OFF_CFG0)) begin
                top_next.div = S_AXI_WDATA[DIV_W-1:0];
                // A zero divisor can never carry the enable
                top_next.en = S_AXI_WDATA[CFG0_EN_BIT] && (S_AXI_WDATA[DIV_W-1:0] != DIV_RESET);
            end else if (addr_hit(S_AXI_AWADDR, OFF_CFG1)) begin
                // Fields are copied into the engine at start, but op is read again at completion to decide whether rxd is captured
                top_next.prtad = S_AXI_WDATA[CFG1_PRT_LSB +: 5];
                top_next.devad = S_AXI_WDATA[CFG1_DEV_LSB +: 5];
                top_next.op = S_AXI_WDATA[CFG1_OP_LSB +: 2];
                if (S_AXI_WDATA[CFG1_START_BIT] && !top_reg.busy && top_reg.en) begin
                    top_next.busy = 1'b1;
                    top_next.start_p = 1'b1;
                end
            end else if (addr_hit(S_AXI_AWADDR, OFF_TXD)) begin
                top_next.txd = S_AXI_WDATA[15:0];
            end else if (!addr_hit(S_AXI_AWADDR, OFF_RXD)) begin
                top_next.bresp = RESP_SLVERR;
            end
        end else if (top_reg.bvalid) begin
            if (S_AXI_BREADY) begin
                top_next.bvalid = 1'b0;
            end
        end else if (S_AXI_AWVALID && S_AXI_WVALID) begin
            top_next.awready = 1'b1;
            top_next.wready = 1'b1;
        end
        // Read channel
        if (top_reg.arready) begin
            top_next.arready = 1'b0;
            top_next.rvalid = 1'b1;
            top_next.rresp = RESP_OKAY;
            top_next.rdata = '0;
            if (addr_hit(S_AXI_ARADDR, OFF_CFG0)) begin
                top_next.rdata[DIV_W-1:0] = top_reg.div;
                top_next.rdata[CFG0_EN_BIT] = top_reg.en;
            end else if (addr_hit(S_AXI_ARADDR, OFF_CFG1)) begin
                top_next.rdata = cfg1_view(top_reg);
            end else if (addr_hit(S_AXI_ARADDR, OFF_TXD)) begin
                top_next.rdata[15:0] = top_reg.txd;
            end else if (addr_hit(S_AXI_ARADDR, OFF_RXD)) begin
                top_next.rdata[15:0] = top_reg.rxd;
            end else begin
                top_next.rresp = RESP_SLVERR;
            end
        end else if (top_reg.rvalid) begin
            if (S_AXI_RREADY) begin
                top_next.rvalid = 1'b0;
            end
        end else if (S_AXI_ARVALID) begin
            top_next.arready = 1'b1;
        end
        // Frame completion; a start cannot coincide because start needs ready
        if (eng_done) begin
            top_next.busy = 1'b0;
            if (top_reg.op[1]) begin
                top_next.rxd = eng_rxd;
            end
        end
    end

    // State register, cleared by the asynchronous reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            top_reg <= '{div: DIV_RESET, default: '0};
        end else begin
            top_reg <= top_next;
        end
    end

    assign S_AXI_AWREADY = top_reg.awready;
    assign S_AXI_WREADY = top_reg.wready;
    assign S_AXI_BVALID = top_reg.bvalid;
    assign S_AXI_BRESP = top_reg.bresp;
    assign S_AXI_ARREADY = top_reg.arready;
    assign S_AXI_RVALID = top_reg.rvalid;
    assign S_AXI_RRESP = top_reg.rresp;
    assign S_AXI_RDATA = top_reg.rdata;

    // ********************************************************
    // Serial engine
    // ********************************************************
    mdm_engine u_engine (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .start(top_reg.start_p),
        .div(top_reg.div),
        .op(top_reg.op),
        .prtad(top_reg.prtad),
        .devad(top_reg.devad),
        .txd(top_reg.txd),
        .done(eng_done),
        .rxd(eng_rxd),
        .mdc(MDC),
        .mdio_in(MDIO_IN),
        .mdio_out(MDIO_OUT),
        .mdio_oe_n(MDIO_OE_N)
    );

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_unmapped_err;
        @(posedge REF_CLK) disable iff (!RST_N)
        (top_reg.awready && !addr_hit(S_AXI_AWADDR, OFF_CFG0) && !addr_hit(S_AXI_AWADDR, OFF_CFG1)
            && !addr_hit(S_AXI_AWADDR, OFF_TXD) && !addr_hit(S_AXI_AWADDR, OFF_RXD))
            |=> S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped write not refused");

    property p_resp_legal;
        @(posedge REF_CLK) disable iff (!RST_N)
        S_AXI_RVALID |-> S_AXI_RRESP == RESP_OKAY || S_AXI_RRESP == RESP_SLVERR;
    endproperty
    a_resp_legal: assert property (p_resp_legal) else $error("Illegal read response");

    property p_upper_ignored;
        @(posedge REF_CLK) disable iff (!RST_N)
        (top_reg.arready && S_AXI_ARADDR[ADDR_W-1:0] == OFF_CFG1) |=> S_AXI_RRESP == RESP_OKAY
            && S_AXI_RDATA[CFG1_READY_BIT] == !$past(top_reg.busy);
    endproperty
    a_upper_ignored: assert property (p_upper_ignored) else $error("Upper address bits decoded");

    property p_enable_needs_div;
        @(posedge REF_CLK) disable iff (!RST_N)
        top_reg.en |-> top_reg.div != DIV_RESET;
    endproperty
    a_enable_needs_div: assert property (p_enable_needs_div) else $error("Enabled with zero divisor");

    property p_start;
        @(posedge REF_CLK) disable iff (!RST_N)
        (top_reg.awready && addr_hit(S_AXI_AWADDR, OFF_CFG1) && S_AXI_WDATA[CFG1_START_BIT]
            && !top_reg.busy && top_reg.en) |=> top_reg.busy && top_reg.start_p ##1 !MDIO_OE_N;
    endproperty
    a_start: assert property (p_start) else $error("Frame did not start");

    property p_no_start_disabled;
        @(posedge REF_CLK) disable iff (!RST_N)
        !top_reg.en |-> !top_reg.start_p;
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled) else $error("Start while disabled");

    // Register view as software would read it, so the check covers both status bits
    logic [31:0] cfg1_now;
    assign cfg1_now = cfg1_view(top_reg);

    property p_done_ready;
        @(posedge REF_CLK) disable iff (!RST_N)
        eng_done |=> cfg1_now[CFG1_READY_BIT] && !cfg1_now[CFG1_START_BIT];
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("Ready not set on completion");

    property p_rx_capture;
        @(posedge REF_CLK) disable iff (!RST_N)
        (eng_done && top_reg.op[1]) |=> top_reg.rxd == $past(eng_rxd);
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("Read data not captured");

    c_start: cover property (@(posedge REF_CLK) disable iff (!RST_N) top_reg.start_p);
    c_slverr: cover property (@(posedge REF_CLK) disable iff (!RST_N) S_AXI_BRESP == RESP_SLVERR);
    c_inc_done: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        eng_done && top_reg.op == OP_READ_INC);

endmodule : mdm_top

// [testbench/mdm_phy_model.sv]
// Behavioural management device on the far side of the serial link
`timescale 1ns/1ps
module mdm_phy_model #(
    parameter logic [4:0] PRT = 5'h07,
    parameter logic [4:0] DEV = 5'h03
) (
    // Serial pins
    input wire logic mdc,
    input wire logic line,
    output logic drv,
    // Observation of the last complete frame
    output logic [63:0] last_frame,
    output int frames
);
    logic [63:0] sr = '0;
    logic [15:0] mem [16];
    logic [15:0] cur = '0;
    logic [11:0] hdr = '0;
    int cnt = 0;

    // ****************************************************
    // Register file and line behaviour
    // ****************************************************
    // Known start contents so reads before any write are predictable
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h5A5A ^ (16'(i) * 16'h1111);
        end
        drv = 1'h1;
        frames = 0;
        last_frame = '0;
    end

    // Sample on each rising serial clock; clock stands still between frames
    always @(posedge mdc) begin
        sr = {sr[62:0], line};
        if (cnt == 0) begin
            if (sr[33:0] == 34'h3FFFFFFFC) cnt = 34;
        end else begin
            cnt++;
        end
        if (cnt == 46) hdr = sr[11:0];
        if (cnt == 64) begin
            cnt = 0;
            frames++;
            last_frame = sr;
            // Only the addressed device reacts
            if (hdr[9:0] == {PRT, DEV}) begin
                case (hdr[11:10])
                    2'h0: cur = sr[15:0];
                    2'h1: mem[cur[3:0]] = sr[15:0];
                    2'h2: cur = cur + 16'h1;
                    default: ;
                endcase
            end
        end
    end

    // Drive turnaround zero then data; otherwise release to the pull-up level
    always @(negedge mdc) begin
        if (hdr[9:0] == {PRT, DEV} && hdr[11] && cnt >= 47) begin
            drv = (cnt == 47) ? 1'h0 : mem[cur[3:0]][63 - cnt];
        end else begin
            drv = 1'h1;
        end
    end
endmodule : mdm_phy_model

// [testbench/mdm_top_bench.sv]
// Self-checking bench for the management serial master
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module mdm_top_bench;
    import mdm_pkg::*;
    localparam logic [4:0] PHY_PRT = 5'h07;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, mdc, mdio_out, mdio_oe_n, phy_drv, line;
    logic [1:0] bresp, rresp;
    logic [63:0] last_frame;
    logic [15:0] mirror [16];
    logic [15:0] cur = '0, phy_reg = '0;
    logic [5:0] div = 6'h00;
    int frames, failures = 0, total_checks = 0, cycles = 0, hi = 0, last_hi = 0;

    // ****************************************************
    // Clock, wire and instances
    // ****************************************************
    always #50 ref_clk = ~ref_clk;
    // Shared data line: whoever holds the enable wins, else the pull-up
    assign line = mdio_oe_n ? phy_drv : mdio_out;

    mdm_top mdm_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MDC(mdc),
        .MDIO_IN(line), .MDIO_OUT(mdio_out), .MDIO_OE_N(mdio_oe_n));
    mdm_phy_model #(.PRT(PHY_PRT), .DEV(5'h03)) mdm_phy_model_inst (.mdc(mdc), .line(line),
        .drv(phy_drv), .last_frame(last_frame), .frames(frames));

    // Cycle ceiling, and width of the last serial clock high phase
    always @(posedge ref_clk) begin
        cycles++;
        if (mdc) hi++;
        else if (hi != 0) begin
            last_hi = hi;
            hi = 0;
        end
        if (cycles > 40000) begin
            failures++;
            print_verdict();
        end
    end

    // ****************************************************
    // Bus tasks; upper address bits are random since only [10:0] decode
    // ****************************************************
    task automatic axi_wr(input logic [10:0] off, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(negedge ref_clk);
        awaddr = ($urandom() & 32'hFFFFF800) | {21'h0, off};
        wdata = d;
        awvalid = 1'h1;
        wvalid = 1'h1;
        do @(posedge ref_clk); while (awready !== 1'h1 && ++n < 20);
        @(negedge ref_clk);
        awvalid = 1'h0;
        wvalid = 1'h0;
        bready = 1'h1;
        do @(posedge ref_clk); while (bvalid !== 1'h1 && ++n < 20);
        `CHK({bvalid, bresp}, {1'h1, er})
        @(negedge ref_clk);
        bready = 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [10:0] off, output logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(negedge ref_clk);
        araddr = ($urandom() & 32'hFFFFF800) | {21'h0, off};
        arvalid = 1'h1;
        do @(posedge ref_clk); while (arready !== 1'h1 && ++n < 20);
        @(negedge ref_clk);
        arvalid = 1'h0;
        rready = 1'h1;
        do @(posedge ref_clk); while (rvalid !== 1'h1 && ++n < 20);
        d = rdata;
        `CHK({rvalid, rresp}, {1'h1, er})
        @(negedge ref_clk);
        rready = 1'h0;
    endtask : axi_rd

    task automatic chk_rd(input logic [10:0] off, input logic [31:0] e);
        logic [31:0] d;
        axi_rd(off, d, RESP_OKAY);
        `CHK(d, e)
    endtask : chk_rd

    // One complete frame, polled to completion, checked on the wire and in registers
    task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [15:0] txd);
        logic [31:0] f;
        logic [15:0] dat;
        logic hit;
        int n = 0;
        int fr;
        f = {3'h0, prt, 3'h0, 5'h03, op, 14'h0};
        hit = (prt == PHY_PRT);
        dat = !op[1] ? txd : (hit ? mirror[cur[3:0]] : 16'hFFFF);
        fr = frames;
        axi_wr(OFF_TXD, {16'h0, txd}, RESP_OKAY);
        axi_wr(OFF_CFG1, f | 32'h800, RESP_OKAY);
        chk_rd(OFF_CFG1, f | 32'h800);
        axi_wr(OFF_CFG1, f | 32'h800, RESP_OKAY);
        do axi_rd(OFF_CFG1, rd, RESP_OKAY); while (rd[7] !== 1'h1 && ++n < 400);
        `CHK(rd, f | 32'h80)
        `CHK(frames, fr + 1)
        `CHK(last_frame, {PREAMBLE, START_CODE, op, prt, 5'h03, (op[1] && !hit) ? 2'h3 : TA_WRITE, dat})
        `CHK(last_hi, int'(div) + 1)
        `CHK({mdc, mdio_oe_n}, 2'h1)
        if (op[1]) chk_rd(OFF_RXD, {16'h0, dat});
        if (hit && op == OP_ADDR) cur = txd;
        if (hit && op == OP_WRITE) mirror[cur[3:0]] = txd;
        if (hit && op == OP_READ_INC) cur = cur + 16'h1;
    endtask : frame

    task automatic print_verdict();
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        void'($urandom(36));
        for (int i = 0; i < 16; i++) mirror[i] = 16'h5A5A ^ (16'(i) * 16'h1111);
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'h1;
        `CHK({mdc, mdio_oe_n, awready, bvalid, rvalid}, 5'h08)
        chk_rd(OFF_CFG0, 32'h0);
        chk_rd(OFF_CFG1, 32'h80);
        // Enable with a zero divisor is refused, so a start does nothing
        axi_wr(OFF_CFG0, 32'h40, RESP_OKAY);
        chk_rd(OFF_CFG0, 32'h0);
        axi_wr(OFF_CFG1, 32'h07030800, RESP_OKAY);
        chk_rd(OFF_CFG1, 32'h07030080);
        // Unmapped places answer with an error; the receive word is read-only
        axi_wr(11'h510, $urandom(), RESP_SLVERR);
        axi_rd(11'h000, rd, RESP_SLVERR);
        axi_rd(11'h7FC, rd, RESP_SLVERR);
        axi_wr(OFF_RXD, 32'h1234, RESP_OKAY);
        chk_rd(OFF_RXD, 32'h0);
        for (int k = 0; k < 3; k++) begin
            // Divisor 1..3 keeps the serial clock at or below 2.5 MHz
            div = 6'($urandom_range(3, 1));
            axi_wr(OFF_CFG0, {25'h0, 1'h1, div}, RESP_OKAY);
            chk_rd(OFF_CFG0, {25'h0, 1'h1, div});
            // Own variable: the polling reads inside a frame overwrite rd
            phy_reg = (k == 0) ? 16'h0002 : 16'(15 - k);
            frame(OP_ADDR, PHY_PRT, phy_reg);
            frame(OP_WRITE, PHY_PRT, 16'($urandom()));
            frame(OP_ADDR, PHY_PRT, phy_reg);
            frame(OP_READ, PHY_PRT, 16'($urandom()));
        end
        // Sequential reads walk through registers 14 and 15, then wrap to register 0
        frame(OP_ADDR, PHY_PRT, 16'h000E);
        repeat (3) frame(OP_READ_INC, PHY_PRT, 16'h0);
        frame(OP_READ, 5'h08, 16'h0);
        // Reset in mid-frame must abandon the frame and clear all management state
        axi_wr(OFF_CFG1, 32'h0703C800, RESP_OKAY);
        repeat (40) @(negedge ref_clk);
        rst_n = 1'h0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'h1;
        `CHK({mdc, mdio_oe_n, awready, bvalid, rvalid}, 5'h08)
        chk_rd(OFF_CFG0, 32'h0);
        chk_rd(OFF_CFG1, 32'h80);
        chk_rd(OFF_RXD, 32'h0);
        print_verdict();
    end
endmodule : mdm_top_bench
